// file: shared/sdma_pkg.sv
package sdma_pkg;

  localparam int NCH = 6;

  // --------------------------------------------------------------------------
  // Register indexes (byte address = 4 * index)
  // --------------------------------------------------------------------------
  localparam logic [7:0] IDX_SRC_PAGE = 8'h28;
  localparam logic [7:0] IDX_DST_PAGE = 8'h29;
  localparam logic [7:0] IDX_GSRC = 8'h30;
  localparam logic [7:0] IDX_GDST = 8'h31;
  localparam logic [7:0] IDX_GCNT = 8'h32;
  localparam logic [7:0] IDX_GFRM = 8'h33;
  localparam logic [7:0] IDX_EIDX0 = 8'h34;
  localparam logic [7:0] IDX_EIDX1 = 8'h35;
  localparam logic [7:0] IDX_FIDX0 = 8'h36;
  localparam logic [7:0] IDX_FIDX1 = 8'h37;
  localparam logic [7:0] IDX_PREC = 8'h38;
  localparam logic [7:0] IDX_STATUS = 8'h39;
  localparam logic [1:0] CH_BLOCK = 2'h1;
  localparam logic [2:0] CR_SRC = 3'h0;
  localparam logic [2:0] CR_DST = 3'h1;
  localparam logic [2:0] CR_CNT = 3'h2;
  localparam logic [2:0] CR_SFC = 3'h3;
  localparam logic [2:0] CR_MODE = 3'h4;

  // --------------------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------------------
  localparam int MC_AUTO = 15;
  localparam int MC_DBL = 14;
  localparam int MC_SRC_OFFCHIP = 11;
  localparam int MC_SRC_INDEX_MODE_LSB = 8;
  localparam int MC_DST_OFFCHIP = 5;
  localparam int MC_DST_INDEX_MODE_LSB = 2;
  localparam int SFC_SYNC_LSB = 12;
  localparam int PREC_HI_LSB = 8;
  localparam int STAT_ERR_LSB = 8;
  localparam int STAT_BUSY = 15;

  localparam logic [2:0] IM_HOLD = 3'h0;
  localparam logic [2:0] IM_INC = 3'h1;
  localparam logic [2:0] IM_DEC = 3'h2;
  localparam logic [2:0] IM_IDX0 = 3'h3;
  localparam logic [2:0] IM_IDX1 = 3'h4;

  localparam logic [15:0] PERIPH_LIMIT = 16'h0060;
  localparam logic [15:0] RST_MODE = 16'h0000;
  localparam logic [7:0] RST_FRAME = 8'h00;

  // --------------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_READ = 3'b010,
    ST_WRITE = 3'b100
  } sdma_st_t;

  typedef struct packed {
    logic req;
    logic we;
    logic ext;
    logic [22:0] addr;
    logic [15:0] wdata;
  } sdma_mem_t;

  typedef struct packed {
    logic [NCH-1:0][15:0] src;
    logic [NCH-1:0][15:0] dst;
    logic [NCH-1:0][15:0] cnt;
    logic [NCH-1:0][15:0] elem_init;
    logic [NCH-1:0][7:0] frm;
    logic [NCH-1:0][3:0] sync_sel;
    logic [NCH-1:0][15:0] mode;
    logic [NCH-1:0] pend;
    logic [NCH-1:0] enable;
    logic [NCH-1:0] hipri;
    logic [NCH-1:0] err;
    logic [NCH-1:0] irq;
    logic [15:0] gsrc;
    logic [15:0] gdst;
    logic [15:0] gcnt;
    logic [7:0] gfrm;
    logic [1:0][15:0] eidx;
    logic [1:0][15:0] fidx;
    logic [6:0] src_page;
    logic [6:0] dst_page;
    sdma_st_t st;
    logic [2:0] cur;
    logic half;
    logic last_el;
    logic last_blk;
    logic [15:0] data;
    logic [2:0] rr_hi;
    logic [2:0] rr_lo;
    logic ap_wr;
    logic [7:0] ap_idx;
    logic rd_wait;
    logic ready;
    logic [31:0] rdata;
    sdma_mem_t mem;
    logic cpu_hold;
  } sdma_state_t;

endpackage

// file: rtl/sdma_top.sv
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/1ps
// Summary of operation
// - Six channels, own context, no CPU help
// - Engine beats CPU on internal accesses
// - Addresses hold, increment, decrement or index
// - Internal transfers wait for selected event
// - Each channel can raise a CPU interrupt
// - Internal double-word elements: two 16-bit transfers
// - One external-read channel, one external-write channel
// - External accesses are single words only
// - No peripheral to/from external memory transfers
// - Mode bit 5 selects off-chip destination
// - Mode bit 11 selects off-chip source
// - Seven-bit source and destination page registers
// - Memory view ignores CPU mapping mode bits
// - High/low priority, round-robin within level
// - Auto_reload_enable reloads addresses and counts, continues
// - Frame counter decrements on frame's last read
// - Frame counter reloads at block end, auto_reload_enable
// - Element counter decrements after each element read but a frame's last
// - Element counter reloads at block end, auto_reload_enable
// - Element index inside frame, frame index last
// - Four-bit event select, zero means free-run
module sdma_top #(
  parameter int EXT_RD_CH = 4,
  parameter int EXT_WR_CH = 5
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack,
  input wire logic [15:0] sync_evt,
  output sdma_pkg::sdma_mem_t mem_out,
  output logic cpu_hold,
  output logic [5:0] chan_irq
);

  sdma_pkg::sdma_state_t s_reg;
  sdma_pkg::sdma_state_t s_next;

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic [15:0] adjust(input logic [15:0] a, input logic [2:0] im, input logic last,
                                         input logic [1:0][15:0] ei, input logic [1:0][15:0] fi);
    logic [15:0] r;
    r = a;
    unique case (im)
      sdma_pkg::IM_INC: r = a + 16'h0001;
      sdma_pkg::IM_DEC: r = a - 16'h0001;
      sdma_pkg::IM_IDX0: r = a + (last ? fi[0] : ei[0]);
      sdma_pkg::IM_IDX1: r = a + (last ? fi[1] : ei[1]);
      default: r = a;
    endcase
    return r;
  endfunction

  // Returns {found, channel}; search starts just after the last one served
  function automatic logic [3:0] rr_pick(input logic [5:0] m, input logic [2:0] last);
    logic [3:0] r;
    int c;
    r = 4'h0;
    for (int i = 6; i >= 1; i--) begin
      c = (int'(last) + i) % 6;
      if (m[c]) begin
        r = {1'b1, 3'(c)};
      end
    end
    return r;
  endfunction

  // Off-chip routing checks; a failing channel is stopped and flagged
  function automatic logic legal(input logic [15:0] md, input logic [15:0] sa, input logic [15:0] da,
                                 input logic [2:0] ch);
    logic sx;
    logic dx;
    logic ok;
    sx = md[sdma_pkg::MC_SRC_OFFCHIP];
    dx = md[sdma_pkg::MC_DST_OFFCHIP];
    ok = 1'b1;
    // Checked at grant, so a bad setup never reaches memory
    if (sx && int'(ch) != EXT_RD_CH) begin
      ok = 1'b0;
    end
    if (dx && int'(ch) != EXT_WR_CH) begin
      ok = 1'b0;
    end
    if (sx && dx) begin
      ok = 1'b0;
    end
    if ((sx || dx) && md[sdma_pkg::MC_DBL]) begin
      ok = 1'b0;
    end
    if (sx && da < sdma_pkg::PERIPH_LIMIT) begin
      ok = 1'b0;
    end
    if (dx && sa < sdma_pkg::PERIPH_LIMIT) begin
      ok = 1'b0;
    end
    return ok;
  endfunction

  function automatic logic [31:0] rd_mux(input sdma_pkg::sdma_state_t s, input logic [7:0] idx);
    logic [31:0] r;
    logic [2:0] c;
    r = 32'h0000_0000;
    c = idx[5:3];
    if (idx[7:6] == sdma_pkg::CH_BLOCK && c < 3'h6) begin
      unique case (idx[2:0])
        sdma_pkg::CR_SRC: r = {16'h0000, s.src[c]};
        sdma_pkg::CR_DST: r = {16'h0000, s.dst[c]};
        sdma_pkg::CR_CNT: r = {16'h0000, s.cnt[c]};
        sdma_pkg::CR_SFC: begin
          r[7:0] = s.frm[c];
          r[sdma_pkg::SFC_SYNC_LSB +: 4] = s.sync_sel[c];
        end
        sdma_pkg::CR_MODE: r = {16'h0000, s.mode[c]};
        default: r = 32'h0000_0000;
      endcase
    end else begin
      unique case (idx)
        sdma_pkg::IDX_SRC_PAGE: r = {25'h0000000, s.src_page};
        sdma_pkg::IDX_DST_PAGE: r = {25'h0000000, s.dst_page};
        sdma_pkg::IDX_GSRC: r = {16'h0000, s.gsrc};
        sdma_pkg::IDX_GDST: r = {16'h0000, s.gdst};
        sdma_pkg::IDX_GCNT: r = {16'h0000, s.gcnt};
        sdma_pkg::IDX_GFRM: r = {24'h000000, s.gfrm};
        sdma_pkg::IDX_EIDX0: r = {16'h0000, s.eidx[0]};
        sdma_pkg::IDX_EIDX1: r = {16'h0000, s.eidx[1]};
        sdma_pkg::IDX_FIDX0: r = {16'h0000, s.fidx[0]};
        sdma_pkg::IDX_FIDX1: r = {16'h0000, s.fidx[1]};
        sdma_pkg::IDX_PREC: begin
          r[5:0] = s.enable;
          r[sdma_pkg::PREC_HI_LSB +: 6] = s.hipri;
        end
        sdma_pkg::IDX_STATUS: begin
          r[5:0] = s.enable;
          r[sdma_pkg::STAT_ERR_LSB +: 6] = s.err;
          r[sdma_pkg::STAT_BUSY] = s.st != sdma_pkg::ST_IDLE;
        end
        default: r = 32'h0000_0000;
      endcase
    end
    return r;
  endfunction

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    logic [5:0] rdy;
    logic [3:0] pk;
    logic [2:0] c;
    logic [2:0] wc;
    logic dbl;
    logic el_done;
    logic lastel;
    logic [15:0] wd;
    rdy = '0;
    pk = '0;
    c = s_reg.cur;
    wc = s_reg.ap_idx[5:3];
    dbl = s_reg.mode[s_reg.cur][sdma_pkg::MC_DBL];
    el_done = 1'b0;
    lastel = 1'b0;
    wd = hwdata[15:0];
    s_next = s_reg;
    s_next.irq = '0;
    s_next.ready = 1'b1;
    s_next.rd_wait = 1'b0;

    // ----------------------------------------
    // Bus slave: reads take one wait state so a write just before is seen
    // ----------------------------------------
    if (s_reg.rd_wait) begin
      s_next.rdata = rd_mux(s_reg, s_reg.ap_idx);
    end
    if (s_reg.ap_wr) begin
      if (s_reg.ap_idx[7:6] == sdma_pkg::CH_BLOCK && wc < 3'h6) begin
        unique case (s_reg.ap_idx[2:0])
          sdma_pkg::CR_SRC: s_next.src[wc] = wd;
          sdma_pkg::CR_DST: s_next.dst[wc] = wd;
          sdma_pkg::CR_CNT: begin
            s_next.cnt[wc] = wd;
            s_next.elem_init[wc] = wd;
          end
          sdma_pkg::CR_SFC: begin
            s_next.sync_sel[wc] = wd[sdma_pkg::SFC_SYNC_LSB +: 4];
            s_next.frm[wc] = wd[7:0];
          end
          sdma_pkg::CR_MODE: s_next.mode[wc] = wd;
          default: s_next.mode[wc] = s_reg.mode[wc];
        endcase
      end else begin
        unique case (s_reg.ap_idx)
          sdma_pkg::IDX_SRC_PAGE: s_next.src_page = wd[6:0];
          sdma_pkg::IDX_DST_PAGE: s_next.dst_page = wd[6:0];
          sdma_pkg::IDX_GSRC: s_next.gsrc = wd;
          sdma_pkg::IDX_GDST: s_next.gdst = wd;
          sdma_pkg::IDX_GCNT: s_next.gcnt = wd;
          sdma_pkg::IDX_GFRM: s_next.gfrm = wd[7:0];
          sdma_pkg::IDX_EIDX0: s_next.eidx[0] = wd;
          sdma_pkg::IDX_EIDX1: s_next.eidx[1] = wd;
          sdma_pkg::IDX_FIDX0: s_next.fidx[0] = wd;
          sdma_pkg::IDX_FIDX1: s_next.fidx[1] = wd;
          sdma_pkg::IDX_PREC: begin
            s_next.enable = wd[5:0];
            s_next.hipri = wd[sdma_pkg::PREC_HI_LSB +: 6];
          end
          sdma_pkg::IDX_STATUS: s_next.err = s_reg.err & ~wd[sdma_pkg::STAT_ERR_LSB +: 6];
          default: s_next.ap_wr = 1'b0;
        endcase
      end
    end
    s_next.ap_wr = 1'b0;
    if (hsel && htrans[1] && hready) begin
      s_next.ap_idx = haddr[9:2];
      s_next.ap_wr = hwrite;
      if (!hwrite) begin
        s_next.rd_wait = 1'b1;
        s_next.ready = 1'b0;
      end
    end

    // ----------------------------------------
    // Engine; addresses are plain 16-bit plus page, no CPU mapping bits
    // ----------------------------------------
    unique case (s_reg.st)
      sdma_pkg::ST_IDLE: begin
        for (int i = 0; i < sdma_pkg::NCH; i++) begin
          rdy[i] = s_reg.enable[i] && (s_reg.sync_sel[i] == 4'h0 || s_reg.pend[i]);
        end
        pk = rr_pick(rdy & s_reg.hipri, s_reg.rr_hi);
        if (!pk[3]) begin
          pk = rr_pick(rdy & ~s_reg.hipri, s_reg.rr_lo);
        end
        if (pk[3]) begin
          c = pk[2:0];
          s_next.pend[c] = 1'b0;
          if (!legal(s_reg.mode[c], s_reg.src[c], s_reg.dst[c], c)) begin
            s_next.enable[c] = 1'b0;
            s_next.err[c] = 1'b1;
          end else begin
            s_next.cur = c;
            s_next.half = 1'b0;
            s_next.mem.req = 1'b1;
            s_next.mem.we = 1'b0;
            s_next.mem.ext = s_reg.mode[c][sdma_pkg::MC_SRC_OFFCHIP];
            s_next.mem.addr = {s_reg.mode[c][sdma_pkg::MC_SRC_OFFCHIP] ? s_reg.src_page : 7'h00, s_reg.src[c]};
            s_next.st = sdma_pkg::ST_READ;
          end
        end
      end
      sdma_pkg::ST_READ: begin
        if (mem_ack) begin
          s_next.data = mem_rdata;
          lastel = s_reg.cnt[c] == 16'h0000 && (!dbl || s_reg.half);
          s_next.last_el = lastel;
          s_next.src[c] = adjust(s_reg.src[c], s_reg.mode[c][sdma_pkg::MC_SRC_INDEX_MODE_LSB +: 3], lastel,
                                 s_reg.eidx, s_reg.fidx);
          s_next.last_blk = 1'b0;
          if (!dbl || s_reg.half) begin
            if (s_reg.cnt[c] != 16'h0000) begin
              s_next.cnt[c] = s_reg.cnt[c] - 16'h0001;
            end else if (s_reg.frm[c] != 8'h00) begin
              s_next.frm[c] = s_reg.frm[c] - 8'h01;
              s_next.cnt[c] = s_reg.elem_init[c];
            end else begin
              s_next.last_blk = 1'b1;
            end
          end
          s_next.mem.we = 1'b1;
          s_next.mem.ext = s_reg.mode[c][sdma_pkg::MC_DST_OFFCHIP];
          s_next.mem.addr = {s_reg.mode[c][sdma_pkg::MC_DST_OFFCHIP] ? s_reg.dst_page : 7'h00, s_reg.dst[c]};
          s_next.mem.wdata = mem_rdata;
          s_next.st = sdma_pkg::ST_WRITE;
        end
      end
      sdma_pkg::ST_WRITE: begin
        if (mem_ack) begin
          s_next.dst[c] = adjust(s_reg.dst[c], s_reg.mode[c][sdma_pkg::MC_DST_INDEX_MODE_LSB +: 3], s_reg.last_el,
                                 s_reg.eidx, s_reg.fidx);
          if (dbl && !s_reg.half) begin
            // Second half of the 32-bit element goes without re-arbitration
            s_next.half = 1'b1;
            s_next.mem.we = 1'b0;
            s_next.mem.ext = 1'b0;
            s_next.mem.addr = {7'h00, s_next.src[c]};
            s_next.st = sdma_pkg::ST_READ;
          end else begin
            el_done = 1'b1;
            s_next.mem.req = 1'b0;
            s_next.mem.we = 1'b0;
            s_next.st = sdma_pkg::ST_IDLE;
          end
        end
      end
      default: s_next.st = sdma_pkg::ST_IDLE;
    endcase

    // ----------------------------------------
    // Element end: pointer; block end: interrupt, then reload if auto_reload_enable, else disable
    // ----------------------------------------
    if (el_done) begin
      if (s_reg.hipri[c]) begin
        s_next.rr_hi = c;
      end else begin
        s_next.rr_lo = c;
      end
      if (s_reg.last_blk) begin
        s_next.irq[c] = 1'b1;
        if (s_reg.mode[c][sdma_pkg::MC_AUTO]) begin
          s_next.src[c] = s_reg.gsrc;
          s_next.dst[c] = s_reg.gdst;
          s_next.cnt[c] = s_reg.gcnt;
          s_next.elem_init[c] = s_reg.gcnt;
          s_next.frm[c] = s_reg.gfrm;
        end else begin
          s_next.enable[c] = 1'b0;
        end
      end
    end

    // ----------------------------------------
    // An event in the cycle its flag is consumed survives
    // ----------------------------------------
    for (int i = 0; i < sdma_pkg::NCH; i++) begin
      if (s_reg.sync_sel[i] != 4'h0 && sync_evt[s_reg.sync_sel[i]]) begin
        s_next.pend[i] = 1'b1;
      end
    end
    // Registered beside the request so the CPU yields in the same cycle
    s_next.cpu_hold = s_next.mem.req && !s_next.mem.ext;
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '0;
      s_reg.st <= sdma_pkg::ST_IDLE;
      s_reg.ready <= 1'b1;
      s_reg.rr_hi <= 3'h5;
      s_reg.rr_lo <= 3'h5;
      for (int i = 0; i < sdma_pkg::NCH; i++) begin
        s_reg.mode[i] <= sdma_pkg::RST_MODE;
        s_reg.frm[i] <= sdma_pkg::RST_FRAME;
      end
    end else begin
      s_reg <= s_next;
    end
  end

  assign hreadyout = s_reg.ready;
  assign hrdata = s_reg.rdata;
  assign hresp = 1'b0;
  assign mem_out = s_reg.mem;
  assign cpu_hold = s_reg.cpu_hold;
  assign chan_irq = s_reg.irq;

endmodule

// file: verif/sdma_props.sv
`timescale 1ns/1ps
// ------
// Port checker
// ------
module sdma_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic mem_ack,
  input wire sdma_pkg::sdma_mem_t mem_out,
  input wire logic cpu_hold,
  input wire logic [5:0] chan_irq
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence bus_req(wr);
    hsel && htrans[1] && hready && (hwrite == wr);
  endsequence
  sequence read_answer;
    !hreadyout ##1 hreadyout;
  endsequence
  sequence ack_of(we, ext);
    mem_out.req && mem_ack && (mem_out.we == we) && (mem_out.ext == ext);
  endsequence
  chk_read_wait: assert property (bus_req(1'b0) |=> read_answer)
    else $error("read answer timing wrong");
  chk_write_nowait: assert property (bus_req(1'b1) |=> hreadyout)
    else $error("write data phase stalled");
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("error response");
  chk_req_stands: assert property (mem_out.req && !mem_ack |=> mem_out.req && $stable(mem_out.addr)
    && $stable(mem_out.we) && $stable(mem_out.ext)) else $error("memory request changed before ack");
  chk_write_follows: assert property (mem_out.req && mem_ack && !mem_out.we |=> mem_out.req && mem_out.we)
    else $error("read not followed by write");
  chk_ext_single: assert property (ack_of(1'b1, 1'b1) |=> !mem_out.req)
    else $error("off-chip write not single");
  chk_ext_read_only: assert property (ack_of(1'b0, 1'b1) |=> mem_out.req && !mem_out.ext)
    else $error("off-chip read channel wrote off-chip");
  chk_page_onchip: assert property (mem_out.req && !mem_out.ext |-> mem_out.addr[22:16] == 7'h00)
    else $error("on-chip access carries a page");
  chk_hold_internal: assert property (cpu_hold == (mem_out.req && !mem_out.ext))
    else $error("cpu hold does not match internal request");
  chk_irq_pulse: assert property ((chan_irq & $past(chan_irq)) == 6'h00)
    else $error("interrupt longer than one cycle");
endmodule
bind sdma_top sdma_props sdma_props_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .mem_ack(mem_ack),
  .mem_out(mem_out), .cpu_hold(cpu_hold), .chan_irq(chan_irq));

// file: verif/sdma_mem_model.sv
`timescale 1ns/1ps
// ------
// Memory partner: acks after a set stall, logs every access
// ------
module sdma_mem_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire sdma_pkg::sdma_mem_t mem_out,
  input wire logic [1:0] stall,
  output logic [15:0] mem_rdata,
  output logic mem_ack
);
  logic [1:0] wait_cnt;
  logic [40:0] log_q[$];
  // Read data follows the address so the bench can predict it
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_ack <= 1'b0;
      wait_cnt <= 2'h0;
      mem_rdata <= 16'hFFFF;
    end else if (mem_out.req && !mem_ack && wait_cnt == stall) begin
      mem_ack <= 1'b1;
      wait_cnt <= 2'h0;
      mem_rdata <= mem_out.addr[15:0] ^ 16'h5A5A;
      log_q.push_back({mem_out.we, mem_out.ext, mem_out.addr,
        mem_out.we ? mem_out.wdata : mem_out.addr[15:0] ^ 16'h5A5A});
    end else begin
      mem_ack <= 1'b0;
      wait_cnt <= (mem_out.req && !mem_ack) ? wait_cnt + 2'h1 : 2'h0;
      // No stale word between acks
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

// file: verif/sdma_test.sv
`timescale 1ns/1ps
// ------
// Register-level bench
// ------
module sdma_test;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [15:0] sync_evt = 16'h0;
  logic [1:0] stall = 2'h0;
  logic hreadyout;
  logic hresp;
  logic mem_ack;
  logic cpu_hold;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [15:0] mem_rdata;
  logic [5:0] chan_irq;
  sdma_pkg::sdma_mem_t mem_out;
  logic [40:0] e;
  logic [15:0] d[6];
  logic [7:0] regs[4] = '{sdma_pkg::IDX_SRC_PAGE, sdma_pkg::IDX_DST_PAGE, sdma_pkg::IDX_GFRM, 8'h3F};
  logic [15:0] mask[4] = '{16'h007F, 16'h007F, 16'h00FF, 16'h0000};
  logic [15:0] sd[4] = '{16'h0100, 16'h0102, 16'h0107, 16'h0109};
  int irq_cnt[6];
  int bad_count = 0;
  int tests_run = 0;

  always #5 hclk = ~hclk;
  always @(posedge hclk) begin
    foreach (irq_cnt[k]) begin
      if (chan_irq[k] === 1'b1) begin
        irq_cnt[k]++;
      end
    end
  end

  sdma_top sdma_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .sync_evt(sync_evt),
    .mem_out(mem_out), .cpu_hold(cpu_hold), .chan_irq(chan_irq));
  sdma_mem_model sdma_mem_model_inst (.hclk(hclk), .hresetn(hresetn), .mem_out(mem_out), .stall(stall),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack));

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    if (bad_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) bad_count++;
  endtask

  task automatic bus(input logic wr, input logic [7:0] idx, input logic [15:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {22'h0, idx, 2'h0};
    wait_ready();
    htrans <= 2'h0;
    hwdata <= {16'h0, wd};
    wait_ready();
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [15:0] v);
    bus(1'b1, idx, v);
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [15:0] exp);
    bus(1'b0, idx, 16'h0);
    check(rd, {16'h0, exp});
  endtask

  function automatic logic [15:0] im(input logic [2:0] s, input logic [2:0] dm);
    return {5'h0, s, 3'h0, dm, 2'h0};
  endfunction

  task automatic setch(input int ch, input logic [15:0] s, dst, c, f, m);
    logic [15:0] v[5];
    v = '{s, dst, c, f, m};
    foreach (v[r]) wr(8'h40 + 8'(ch * 8 + r), v[r]);
  endtask

  task automatic wait_done(input logic [5:0] en);
    int n;
    n = 0;
    do begin
      bus(1'b0, sdma_pkg::IDX_STATUS, 16'h0);
      n++;
    end while ((rd[5:0] & en) !== 6'h00 && n < 200);
    if ((rd[5:0] & en) !== 6'h00) bad_count++;
  endtask

  task automatic run(input logic [5:0] hi, input logic [5:0] en);
    wr(sdma_pkg::IDX_PREC, {2'h0, hi, 2'h0, en});
    wait_done(en);
  endtask

  task automatic wait_log(input int n);
    for (int i = 0; i < 300 && sdma_mem_model_inst.log_q.size() < n; i++) @(posedge hclk);
    if (sdma_mem_model_inst.log_q.size() < n) bad_count++;
  endtask

  function automatic logic [40:0] pop();
    if (sdma_mem_model_inst.log_q.size() == 0) return {41{1'bx}};
    return sdma_mem_model_inst.log_q.pop_front();
  endfunction

  // Read then write of one word; data is what the model returned
  task automatic xfer(input logic [22:0] sa, input logic sx, input logic [22:0] da, input logic dx);
    logic [15:0] v;
    v = sa[15:0] ^ 16'h5A5A;
    check(pop(), {1'b0, sx, sa, v});
    check(pop(), {1'b1, dx, da, v});
  endtask

  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdchk(8'h40 + {5'h0, sdma_pkg::CR_MODE}, 16'h0000);
    foreach (regs[i]) begin
      rdchk(regs[i], 16'h0000);
      wr(regs[i], 16'hFFFF);
      rdchk(regs[i], mask[i]);
    end
    wr(sdma_pkg::IDX_SRC_PAGE, 16'h0005);
    wr(sdma_pkg::IDX_DST_PAGE, 16'h0006);
    // Slow memory, three elements
    stall <= 2'h3;
    setch(0, 16'h0100, 16'h0200, 16'h0002, 16'h0000, im(sdma_pkg::IM_INC, sdma_pkg::IM_INC));
    run(6'h00, 6'h01);
    for (int i = 0; i < 3; i++) xfer(23'h100 + 23'(i), 1'b0, 23'h200 + 23'(i), 1'b0);
    check(irq_cnt[0], 1);
    stall <= 2'h0;
    setch(1, 16'h0150, 16'h0300, 16'h0001, 16'h0000, im(sdma_pkg::IM_DEC, sdma_pkg::IM_HOLD));
    run(6'h00, 6'h02);
    xfer(23'h150, 1'b0, 23'h300, 1'b0);
    xfer(23'h14F, 1'b0, 23'h300, 1'b0);
    // Two frames of two elements, indexed source
    wr(sdma_pkg::IDX_EIDX0, 16'h0002);
    wr(sdma_pkg::IDX_FIDX0, 16'h0005);
    setch(2, 16'h0100, 16'h0400, 16'h0001, 16'h0001, im(sdma_pkg::IM_IDX0, sdma_pkg::IM_INC));
    run(6'h00, 6'h04);
    foreach (sd[i]) xfer({7'h0, sd[i]}, 1'b0, 23'h400 + 23'(i), 1'b0);
    check(irq_cnt[2], 1);
    // A foreign event must not start the channel
    setch(3, 16'h0120, 16'h0130, 16'h0000, 16'h3000, im(sdma_pkg::IM_INC, sdma_pkg::IM_INC));
    wr(sdma_pkg::IDX_PREC, 16'h0008);
    sync_evt <= 16'h0010;
    repeat (20) @(posedge hclk);
    check(sdma_mem_model_inst.log_q.size(), 0);
    sync_evt <= 16'h0008;
    @(posedge hclk);
    sync_evt <= 16'h0000;
    wait_done(6'h08);
    xfer(23'h120, 1'b0, 23'h130, 1'b0);
    setch(3, 16'h0700, 16'h0800, 16'h0000, 16'h0000, im(sdma_pkg::IM_INC, sdma_pkg::IM_INC) | 16'h4000);
    run(6'h00, 6'h08);
    xfer(23'h700, 1'b0, 23'h800, 1'b0);
    xfer(23'h701, 1'b0, 23'h801, 1'b0);
    // Off-chip source and destination on their own channels
    setch(4, 16'h1234, 16'h0500, 16'h0000, 16'h0000, im(sdma_pkg::IM_INC, sdma_pkg::IM_INC) | 16'h0800);
    run(6'h00, 6'h10);
    xfer({7'h05, 16'h1234}, 1'b1, 23'h500, 1'b0);
    setch(5, 16'h0600, 16'h2222, 16'h0000, 16'h0000, im(sdma_pkg::IM_INC, sdma_pkg::IM_INC) | 16'h0020);
    run(6'h00, 6'h20);
    xfer(23'h600, 1'b0, {7'h06, 16'h2222}, 1'b1);
    setch(0, 16'h0100, 16'h0200, 16'h0000, 16'h0000, 16'h0800);
    setch(5, 16'h0020, 16'h2222, 16'h0000, 16'h0000, 16'h0020);
    run(6'h00, 6'h21);
    check(sdma_mem_model_inst.log_q.size(), 0);
    rdchk(sdma_pkg::IDX_STATUS, 16'h2100);
    wr(sdma_pkg::IDX_STATUS, 16'h3F00);
    rdchk(sdma_pkg::IDX_STATUS, 16'h0000);
    // Auto reload; the source reload is rewritten mid-block
    stall <= 2'h3;
    wr(sdma_pkg::IDX_GSRC, 16'h0B00);
    wr(sdma_pkg::IDX_GDST, 16'h0C00);
    wr(sdma_pkg::IDX_GCNT, 16'h0001);
    wr(sdma_pkg::IDX_GFRM, 16'h0001);
    setch(5, 16'h0900, 16'h0A00, 16'h0000, 16'h0000, im(sdma_pkg::IM_INC, sdma_pkg::IM_INC) | 16'h8000);
    wr(sdma_pkg::IDX_PREC, 16'h0020);
    wait_log(1);
    wr(sdma_pkg::IDX_GSRC, 16'h0D00);
    wait_log(12);
    wr(sdma_pkg::IDX_PREC, 16'h0000);
    repeat (40) @(posedge hclk);
    xfer(23'h900, 1'b0, 23'hA00, 1'b0);
    for (int i = 0; i < 5; i++) xfer(23'hD00 + 23'(i % 4), 1'b0, 23'hC00 + 23'(i % 4), 1'b0);
    sdma_mem_model_inst.log_q.delete();
    stall <= 2'h0;
    // High level first, then the low pair alternates per element
    setch(0, 16'h0100, 16'h0D00, 16'h0001, 16'h0000, im(sdma_pkg::IM_INC, sdma_pkg::IM_INC));
    setch(1, 16'h0200, 16'h0E00, 16'h0001, 16'h0000, im(sdma_pkg::IM_INC, sdma_pkg::IM_INC));
    setch(2, 16'h0300, 16'h0F00, 16'h0001, 16'h0000, im(sdma_pkg::IM_INC, sdma_pkg::IM_INC));
    run(6'h04, 6'h07);
    for (int i = 0; i < 6; i++) begin
      e = pop();
      e = pop();
      d[i] = e[31:16];
    end
    check({d[0], d[1]}, 32'h0F000F01);
    check(d[2] ^ d[3], 16'h0300);
    check({d[4], d[5]}, {d[2] + 16'h1, d[3] + 16'h1});
    final_report();
  end

  initial begin
    #200000;
    bad_count++;
    final_report();
  end
endmodule
